/* File: logic/adcp_cfg.svh */
/*
 holds the constants of the converter output interface: latency, timing counts,
 widths, register addresses and event bits. assumes a 20 MHz system clock; included by bare name.
*/
// Notes on behaviour
// - sample on clock fall, output 8 cycles later
// - equalizer tolerates 35 to 65 percent duty
// - equalizer needs 100 cycles to lock
// - strobe copies clock delayed 5.2ns, equalizer off
// - equalizer on gives fixed strobe pulse width
// - outputs change on strobe fall, valid rising
// - flag high when input beyond span times 3/4
// - flag shares latency, moves with sample bus
// - flag tri-states 10ns after power-down edges
// - format select high gray, low two's complement
// - code maps to fraction of 16384, gray offset 8192
// - 14-bit parallel bus capable of high impedance
// - power-down high enters low-power mode
// - strobe tri-stated during power-down
// - bus tri-states 10ns after power-down edges
`ifndef ADCP_CFG_SVH
`define ADCP_CFG_SVH
`define ADCP_CLK_NS 50
`define ADCP_LATENCY 8
`define ADCP_LOCK_CYCLES 100
`define ADCP_DAV_DELAY_PS 5200
`define ADCP_DAV_DELAY_CYC ((`ADCP_DAV_DELAY_PS + `ADCP_CLK_NS * 1000 - 1) / (`ADCP_CLK_NS * 1000))
`define ADCP_PD_NS 10
`define ADCP_PD_CYC ((`ADCP_PD_NS / `ADCP_CLK_NS) < 1 ? 1 : (`ADCP_PD_NS / `ADCP_CLK_NS))
`define ADCP_DAV_PULSE_CYC 2
`define ADCP_WIDTH 14
`define ADCP_MID_CODE 14'h2000
`define ADCP_FULL_CODE 15'h4000
`define ADCP_RANGE_NUM 3
`define ADCP_RANGE_DEN 4
`define ADCP_REG_STATUS 4'h0
`define ADCP_REG_MASK 4'h1
`define ADCP_REG_STATE 4'h2
`define ADCP_REG_CTRL 4'h3
`define ADCP_EV_OVR 0
`define ADCP_EV_LOCK 1
`define ADCP_EV_PD 2
`define ADCP_EV_BITS 3
`endif

/* File: logic/adcp_pkg.sv */
/*
 holds the types of the converter output interface.
 assumes the cfg header for the widths it mirrors.
*/
package adcp_pkg;
    typedef enum logic [1:0] {
        ADCP_OFF = 2'b00,
        ADCP_WAKE = 2'b01,
        ADCP_LOCK = 2'b11,
        ADCP_RUN = 2'b10
    } adcp_state_t;
    typedef logic [13:0] adcp_word_t;
endpackage

/* File: logic/adcp_sync.sv */
/*
 holds a two flip-flop synchroniser for a vector of pins.
 assumes the pins are quasi-static or sampled by slower logic.
*/
`timescale 1ns/1ps
module adcp_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta;

    // first stage feeds only the second
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            meta <= '0;
            q <= '0;
        end
        else
        begin
            meta <= d;
            q <= meta;
        end
    end
endmodule

/* File: logic/adcp_code.sv */
/*
 holds the output coder: clamps the signed sample to the valid span, flags
 out-of-range and encodes two's complement or gray.
 assumes a combinational use inside the clocked pipeline.
*/
`timescale 1ns/1ps
`include "adcp_cfg.svh"
module adcp_code #(
    parameter int W = `ADCP_WIDTH
) (
    input wire logic signed [W+1:0] sample_in,
    input wire logic format_select,
    output logic [W-1:0] code_out,
    output logic over
);
    localparam logic signed [W+1:0] HI = (W+2)'((1 << (W-1)) - 1);
    localparam logic signed [W+1:0] LO = -(W+2)'(1 << (W-1));
    wire logic is_hi = sample_in > HI;
    wire logic is_lo = sample_in < LO;
    wire logic signed [W+1:0] clamped = is_hi ? HI : (is_lo ? LO : sample_in);
    wire logic [W-1:0] twos = clamped[W-1:0];
    // offset binary is two's complement with top bit inverted
    wire logic [W-1:0] offs = {~twos[W-1], twos[W-2:0]};
    wire logic [W-1:0] gray = offs ^ (offs >> 1);

    // flag and format selection
    assign over = is_hi | is_lo;
    assign code_out = format_select ? gray : twos;
endmodule

/* File: logic/adcp_top.sv */
/*
 holds the digital output side of the pipelined converter: clock edge finder,
 8-cycle result pipe, data-valid strobe, power-down tri-state control, and a
 small status register file with a masked interrupt.
 assumes clock_in_pos comes from another domain and is far slower than clk;
 sample_in is the quantizer result already expressed in the 3/4 span units.
*/
// Our own choices: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`include "adcp_cfg.svh"
module adcp_top #(
    parameter int W = `ADCP_WIDTH,
    parameter int LATENCY = `ADCP_LATENCY,
    parameter int LOCK_CYCLES = `ADCP_LOCK_CYCLES
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic clock_in_pos,
    input wire logic clock_in_neg,
    input wire logic clock_type_select,
    input wire logic duty_equalizer_enable,
    input wire logic format_select,
    input wire logic power_down_pin,
    input wire logic signed [W+1:0] sample_in,
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    output logic irq,
    output logic [W-1:0] sample_bus,
    output logic [W-1:0] sample_bus_oe_b,
    output logic out_of_range_flag,
    output logic out_of_range_flag_oe_b,
    output logic data_valid_strobe,
    output logic data_valid_strobe_oe_b,
    output logic low_power
);
    localparam int DAV_CYC = `ADCP_DAV_DELAY_CYC;
    localparam int PD_CYC = `ADCP_PD_CYC;
    localparam int LAST = LATENCY;

    // synchronised pins
    logic [5:0] pins_s;
    adcp_sync #(.W(6)) u_sync (
        .clk(clk),
        .rst_b(rst_b),
        .d({clock_in_pos, clock_in_neg, clock_type_select, duty_equalizer_enable, format_select, power_down_pin}),
        .q(pins_s)
    );
    wire logic cp_s = pins_s[5];
    wire logic cn_s = pins_s[4];
    wire logic diff_s = pins_s[3];
    wire logic dce_s = pins_s[2];
    wire logic fmt_s = pins_s[1];
    wire logic pd_s = pins_s[0];

    // conversion clock: pos alone when single ended, else pos minus neg
    wire logic conv_clk = diff_s ? (cp_s & ~cn_s) : cp_s;
    logic conv_q;
    always_ff @(posedge clk)
    begin
        if (!rst_b)
            conv_q <= 1'b0;
        else
            conv_q <= conv_clk;
    end
    wire logic clk_fall = conv_q & ~conv_clk;
    wire logic clk_rise = ~conv_q & conv_clk;

    // coder on the sampled value
    logic [W-1:0] code_now;
    logic over_now;
    adcp_code #(.W(W)) u_code (
        .sample_in(sample_in),
        .format_select(fmt_s),
        .code_out(code_now),
        .over(over_now)
    );

    // result pipe advanced once per conversion-clock fall
    // stage 0 takes the sample at its own fall, so stage LAST holds it LATENCY falls later
    logic [W-1:0] pipe_code [LATENCY+1];
    logic pipe_over [LATENCY+1];
    genvar gi;
    generate
        for (gi = 0; gi < LATENCY + 1; gi++)
        begin : g_pipe
            always_ff @(posedge clk)
            begin
                if (!rst_b)
                begin
                    pipe_code[gi] <= '0;
                    pipe_over[gi] <= 1'b0;
                end
                else if (clk_fall)
                begin
                    pipe_code[gi] <= (gi == 0) ? code_now : pipe_code[(gi == 0) ? 0 : gi - 1];
                    pipe_over[gi] <= (gi == 0) ? over_now : pipe_over[(gi == 0) ? 0 : gi - 1];
                end
            end
        end
    endgenerate

    // strobe delay line: edges of the clock delayed by whole cycles
    logic [DAV_CYC-1:0] fall_dly;
    logic [DAV_CYC-1:0] lvl_dly;
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            fall_dly <= '0;
            lvl_dly <= '0;
        end
        else
        begin
            fall_dly <= DAV_CYC'({fall_dly, clk_fall});
            lvl_dly <= DAV_CYC'({lvl_dly, conv_clk});
        end
    end
    wire logic dav_fall_evt = fall_dly[DAV_CYC-1];
    wire logic dav_lvl = lvl_dly[DAV_CYC-1];

    // fixed-width pulse when equalizer on: placed from the last fall spacing so that
    // its falling edge lands on the strobe fall, as with the equalizer off
    logic [15:0] since_fall;
    logic [15:0] fall_period;
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            since_fall <= 16'h0;
            fall_period <= 16'h0;
        end
        else
        begin
            since_fall <= dav_fall_evt ? 16'h0 : since_fall + 16'h1;
            fall_period <= dav_fall_evt ? since_fall : fall_period;
        end
    end
    wire logic pulse_win = since_fall + 16'(`ADCP_DAV_PULSE_CYC) >= fall_period;
    wire logic dav_fixed = !dav_fall_evt && fall_period != 16'h0 && pulse_win && since_fall < fall_period;
    wire logic next_dav = dce_s ? dav_fixed : dav_lvl;

    // power-down state and equalizer lock tracking
    adcp_pkg::adcp_state_t state;
    adcp_pkg::adcp_state_t next_state;
    logic [7:0] tcnt;
    logic [7:0] next_tcnt;
    logic [15:0] period_cnt;
    logic [15:0] last_period;
    wire logic freq_change = clk_rise && (last_period != 16'h0) &&
        ((period_cnt > last_period + 16'h1) || (period_cnt + 16'h1 < last_period));
    wire logic lock_done = tcnt >= 8'(LOCK_CYCLES);
    always_comb
    begin
        next_state = state;
        next_tcnt = tcnt;
        case (state)
            adcp_pkg::ADCP_OFF:
                if (!pd_s)
                begin
                    next_state = adcp_pkg::ADCP_WAKE;
                    next_tcnt = 8'h0;
                end
            adcp_pkg::ADCP_WAKE:
                if (pd_s)
                    next_state = adcp_pkg::ADCP_OFF;
                else if (tcnt + 8'h1 >= 8'(PD_CYC))
                begin
                    next_state = adcp_pkg::ADCP_LOCK;
                    next_tcnt = 8'h0;
                end
                else
                    next_tcnt = tcnt + 8'h1;
            adcp_pkg::ADCP_LOCK:
                if (pd_s)
                    next_state = adcp_pkg::ADCP_OFF;
                else if (!dce_s || lock_done)
                    next_state = adcp_pkg::ADCP_RUN;
                else if (clk_rise)
                    next_tcnt = tcnt + 8'h1;
            default:
                if (pd_s)
                    next_state = adcp_pkg::ADCP_OFF;
                else if (dce_s && freq_change)
                begin
                    next_state = adcp_pkg::ADCP_LOCK;
                    next_tcnt = 8'h0;
                end
        endcase
    end
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            state <= adcp_pkg::ADCP_OFF;
            tcnt <= 8'h0;
            period_cnt <= 16'h0;
            last_period <= 16'h0;
        end
        else
        begin
            state <= next_state;
            tcnt <= next_tcnt;
            period_cnt <= clk_rise ? 16'h0 : period_cnt + 16'h1;
            last_period <= clk_rise ? period_cnt : last_period;
        end
    end
    wire logic drive_on = state != adcp_pkg::ADCP_OFF && state != adcp_pkg::ADCP_WAKE;
    wire logic locked = state == adcp_pkg::ADCP_RUN;

    // pin drivers: bus changes at strobe fall, stable at its rise
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            sample_bus <= '0;
            out_of_range_flag <= 1'b0;
            data_valid_strobe <= 1'b0;
            sample_bus_oe_b <= '1;
            out_of_range_flag_oe_b <= 1'b1;
            data_valid_strobe_oe_b <= 1'b1;
            low_power <= 1'b1;
        end
        else
        begin
            if (dav_fall_evt)
            begin
                sample_bus <= pipe_code[LAST];
                out_of_range_flag <= pipe_over[LAST];
            end
            data_valid_strobe <= next_dav;
            sample_bus_oe_b <= {W{~drive_on}};
            out_of_range_flag_oe_b <= ~drive_on;
            data_valid_strobe_oe_b <= ~drive_on;
            low_power <= pd_s;
        end
    end

    // status events, write one to clear, set wins
    logic [`ADCP_EV_BITS-1:0] status;
    logic [`ADCP_EV_BITS-1:0] mask;
    logic locked_q;
    logic pd_q;
    wire logic [`ADCP_EV_BITS-1:0] ev = {pd_s & ~pd_q, locked & ~locked_q, dav_fall_evt & pipe_over[LAST]};
    wire logic wr_status = reg_wr && reg_addr == `ADCP_REG_STATUS;
    wire logic wr_mask = reg_wr && reg_addr == `ADCP_REG_MASK;
    wire logic [`ADCP_EV_BITS-1:0] clr = wr_status ? reg_wdata[`ADCP_EV_BITS-1:0] : '0;
    wire logic [31:0] rd_mux =
        (reg_addr == `ADCP_REG_STATUS) ? 32'(status) :
        (reg_addr == `ADCP_REG_MASK) ? 32'(mask) :
        (reg_addr == `ADCP_REG_STATE) ? {28'h0, locked, drive_on, state} :
        (reg_addr == `ADCP_REG_CTRL) ? {27'h0, pd_s, fmt_s, dce_s, diff_s, cp_s} : 32'h0;
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            status <= '0;
            mask <= '0;
            locked_q <= 1'b0;
            pd_q <= 1'b0;
            reg_rdata <= 32'h0;
            irq <= 1'b0;
        end
        else
        begin
            status <= (status & ~clr) | ev;
            mask <= wr_mask ? reg_wdata[`ADCP_EV_BITS-1:0] : mask;
            locked_q <= locked;
            pd_q <= pd_s;
            reg_rdata <= reg_rd ? rd_mux : 32'h0;
            irq <= |(((status & ~clr) | ev) & (wr_mask ? reg_wdata[`ADCP_EV_BITS-1:0] : mask));
        end
    end

    // checks
    property p_pd_float;
        @(posedge clk) disable iff (!rst_b) $rose(pd_s) |=> ##1 (&sample_bus_oe_b && out_of_range_flag_oe_b);
    endproperty
    a_pd_float: assert property (p_pd_float) else $error("bus not released after power-down");
    property p_dav_float;
        @(posedge clk) disable iff (!rst_b) (state == adcp_pkg::ADCP_OFF) |=> data_valid_strobe_oe_b;
    endproperty
    a_dav_float: assert property (p_dav_float) else $error("strobe driven in power-down");
    property p_bus_at_fall;
        @(posedge clk) disable iff (!rst_b) !$past(dav_fall_evt) |-> $stable(sample_bus);
    endproperty
    a_bus_at_fall: assert property (p_bus_at_fall) else $error("bus moved outside strobe fall");
    property p_dav_copy;
        @(posedge clk) disable iff (!rst_b) !dce_s ##1 !$past(dce_s) |-> data_valid_strobe == $past(dav_lvl);
    endproperty
    a_dav_copy: assert property (p_dav_copy) else $error("strobe not a delayed clock copy");
    property p_fixed_pulse;
        @(posedge clk) disable iff (!rst_b) (dce_s && $rose(dav_fixed)) |=> dav_fixed ##1 !dav_fixed;
    endproperty
    a_fixed_pulse: assert property (p_fixed_pulse) else $error("strobe pulse width wrong");
    property p_flag_with_bus;
        @(posedge clk) disable iff (!rst_b) dav_fall_evt |=> out_of_range_flag == $past(pipe_over[LAST]);
    endproperty
    a_flag_with_bus: assert property (p_flag_with_bus) else $error("flag not aligned with bus");
    property p_lock_wait;
        @(posedge clk) disable iff (!rst_b) (state == adcp_pkg::ADCP_LOCK && dce_s && !pd_s && tcnt < 8'(LOCK_CYCLES))
            |=> !locked;
    endproperty
    a_lock_wait: assert property (p_lock_wait) else $error("locked too early");
    property p_irq;
        @(posedge clk) disable iff (!rst_b) $rose(pd_s) && mask[`ADCP_EV_PD] |=> irq;
    endproperty
    a_irq: assert property (p_irq) else $error("power-down event lost");
endmodule

/* File: dv/adcp_cap.sv */
/*
 back-end capture model: latches word and flag on each strobe rise,
 times the strobe and watches that the bus holds while it is high.
 assumes the strobe and pins arrive at clk rate, z when floated.
*/
`timescale 1ns/1ps
module adcp_cap (
    input wire logic clk,
    input wire logic clock_in_pos,
    input wire logic data_valid_strobe,
    input wire logic [13:0] sample_bus,
    input wire logic out_of_range_flag,
    output logic [13:0] cap_word,
    output logic cap_flag,
    output int hi_width,
    output int fall_lag,
    output int hold_errs
);
    logic prev_s = 1'b0;
    logic prev_p = 1'b0;
    logic [13:0] prev_bus;
    int hi_cnt = 0;
    int lag = 0;
    initial hold_errs = 0;
    // latch on strobe rise, measure width and lag from clock fall
    always @(posedge clk)
    begin
        prev_s <= data_valid_strobe === 1'b1;
        prev_p <= clock_in_pos;
        prev_bus <= sample_bus;
        lag <= (prev_p && !clock_in_pos) ? 1 : lag + 1;
        hi_cnt <= (data_valid_strobe === 1'b1) ? hi_cnt + 1 : 0;
        if (data_valid_strobe === 1'b1 && !prev_s)
        begin
            cap_word <= sample_bus;
            cap_flag <= out_of_range_flag;
        end
        if (data_valid_strobe === 1'b1 && prev_s && sample_bus !== prev_bus)
            hold_errs <= hold_errs + 1;
        if (data_valid_strobe !== 1'b1 && prev_s)
        begin
            hi_width <= hi_cnt;
            fall_lag <= lag;
        end
    end
endmodule

/* File: dv/adcp_top_tb_top.sv */
/*
 testbench of the converter output side: runs conversion clock frames,
 checks coded words, strobe, power-down floating and status registers.
 assumes the capture model beside it and a 20 MHz clk.
*/
`timescale 1ns/1ps
module adcp_top_tb_top;
    localparam int LOCK = 12;
    localparam int FALL_LAG = 4;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic clock_in_pos = 1'b0;
    logic clock_in_neg = 1'b0;
    logic clock_type_select = 1'b0;
    logic duty_equalizer_enable = 1'b0;
    logic format_select = 1'b0;
    logic power_down_pin = 1'b0;
    logic signed [15:0] sample_in = 16'h0000;
    logic [3:0] reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic [31:0] rd;
    logic irq, out_of_range_flag, out_of_range_flag_oe_b, data_valid_strobe, data_valid_strobe_oe_b, low_power;
    logic [13:0] sample_bus, sample_bus_oe_b, cap_word;
    logic cap_flag;
    wire [13:0] bus_pin;
    wire flag_pin, dav_pin;
    int hi_width, fall_lag, hold_errs;
    int fails = 0;
    int cmp_count = 0;
    logic signed [15:0] hist [$];
    logic signed [15:0] tbl [8] = '{16'sh1FFF, 16'sh2000, 16'shE000, 16'shDFFF,
        16'sh0000, 16'sh0001, 16'shFFFF, 16'sh1234};

    // clock
    always #25 clk = ~clk;

    // pin levels seen by the back end
    for (genvar i = 0; i < 14; i++)
    begin : g_pin
        assign bus_pin[i] = sample_bus_oe_b[i] ? 1'bz : sample_bus[i];
    end
    assign flag_pin = out_of_range_flag_oe_b ? 1'bz : out_of_range_flag;
    assign dav_pin = data_valid_strobe_oe_b ? 1'bz : data_valid_strobe;

    adcp_top #(.LOCK_CYCLES(LOCK)) dut_u (.clk, .rst_b, .clock_in_pos, .clock_in_neg, .clock_type_select,
        .duty_equalizer_enable, .format_select, .power_down_pin, .sample_in, .reg_addr, .reg_wdata,
        .reg_wr, .reg_rd, .reg_rdata, .irq, .sample_bus, .sample_bus_oe_b, .out_of_range_flag,
        .out_of_range_flag_oe_b, .data_valid_strobe, .data_valid_strobe_oe_b, .low_power);

    adcp_cap cap_u (.clk, .clock_in_pos, .data_valid_strobe(dav_pin), .sample_bus(bus_pin),
        .out_of_range_flag(flag_pin), .cap_word, .cap_flag, .hi_width, .fall_lag, .hold_errs);

    task check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        cmp_count++;
        if (seen !== exp)
        begin
            fails++;
            $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task reg_write(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    task reg_read(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask

    // expected flag and code of one sample
    function automatic logic [14:0] enc(input logic signed [15:0] s, input logic gray);
        logic signed [15:0] c;
        logic [13:0] ob;
        c = (s > 16'sh1FFF) ? 16'sh1FFF : (s < 16'shE000) ? 16'shE000 : s;
        ob = c[13:0] ^ 14'h2000;
        enc = {s != c, gray ? ob ^ (ob >> 1) : c[13:0]};
    endfunction

    // one conversion clock period of 8 clk, sample held across it
    task period(input logic signed [15:0] v);
        clock_in_pos <= 1'b1;
        clock_in_neg <= 1'b0;
        sample_in <= v;
        hist.push_back(v);
        repeat (4) @(posedge clk);
        clock_in_pos <= 1'b0;
        clock_in_neg <= clock_type_select;
        repeat (4) @(posedge clk);
    endtask

    task run(input int n, input logic gray, input logic dce, input logic diff);
        format_select <= gray;
        duty_equalizer_enable <= dce;
        clock_type_select <= diff;
        hist.delete();
        for (int i = 0; i < n; i++)
        begin
            period(tbl[i % 8]);
            if (hist.size() >= 10)
                check({17'h0, cap_flag, cap_word}, {17'h0, enc(hist[hist.size() - 10], gray)}, "word");
        end
        check(hi_width, dce ? 32'h2 : 32'h4, "strobe width");
        check(fall_lag, FALL_LAG, "strobe lag");
        check(hold_errs, 0, "bus hold");
        $display("done: run fmt %0d dce %0d", gray, dce);
    endtask

    task wait_oe(input logic hi, input int lim);
        int n;
        n = 0;
        while (n < 50 && {sample_bus_oe_b, out_of_range_flag_oe_b, data_valid_strobe_oe_b} !== {16{hi}})
        begin
            @(negedge clk);
            n++;
        end
        check(n <= lim, 1, "float delay");
        @(posedge clk);
    endtask

    task test_done;
        $display("counts: %0d compares, %0d fails", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // watchdog
    initial
    begin
        #250000;
        fails++;
        $display("wrong value at %0t: watchdog expired", $time);
        test_done();
    end

    // test sequence
    initial
    begin
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        check({sample_bus_oe_b, out_of_range_flag_oe_b, data_valid_strobe_oe_b}, 32'hFFFF, "reset oe");
        reg_read(4'h1, rd);
        check(rd, 0, "mask reset");
        reg_read(4'h7, rd);
        check(rd, 0, "unmapped");
        reg_read(4'h3, rd);
        check(rd, 0, "pins");
        $display("done: reset");
        run(20, 1'b0, 1'b0, 1'b0);
        reg_read(4'h0, rd);
        check(rd[0], 1, "range status");
        check(irq, 0, "masked irq");
        reg_write(4'h1, 32'h1);
        repeat (2) @(negedge clk);
        check(irq, 1, "irq raised");
        reg_write(4'h0, 32'h1);
        repeat (2) @(negedge clk);
        check(irq, 0, "irq cleared");
        reg_read(4'h0, rd);
        check(rd[0], 0, "status cleared");
        $display("done: interrupt");
        run(20, 1'b1, 1'b1, 1'b1);
        reg_read(4'h0, rd);
        check(rd[1], 1, "lock gained");
        reg_write(4'h0, 32'h2);
        reg_read(4'h0, rd);
        check(rd[1], 0, "lock cleared");
        reg_read(4'h3, rd);
        check(rd, 32'hE, "pins");
        reg_write(4'h1, 32'h4);
        power_down_pin <= 1'b1;
        wait_oe(1'b1, 5);
        check(irq, 1, "pd irq");
        check(low_power, 1, "low power");
        reg_read(4'h0, rd);
        check(rd[2], 1, "pd status");
        power_down_pin <= 1'b0;
        run(20, 1'b0, 1'b1, 1'b0);
        check({sample_bus_oe_b, out_of_range_flag_oe_b, data_valid_strobe_oe_b}, 0, "driving");
        check(low_power, 0, "awake");
        reg_read(4'h0, rd);
        check(rd[1], 1, "relock after wake");
        $display("done: power down");
        test_done();
    end
endmodule
